//--- rtl/srw_pkg.sv
// Package of constants and state types for the supply reset and watchdog block.
// Assumes a single 40 MHz clock; analog comparators arrive as synchronous flags.
package srw_pkg;

	// ==========================================================
	// Timebase
	localparam int unsigned SRW_CLK_HZ = 40000000;
	localparam int unsigned SRW_TICK_NS = 1000;
	localparam int unsigned SRW_TICK_CYC = (SRW_CLK_HZ / 1000000) * SRW_TICK_NS / 1000;
	localparam int SRW_TB_W = 6;

	// ==========================================================
	// Ramp and detector timing, in timebase ticks and ramp cycles
	localparam int SRW_RAMP_W = 16;
	localparam logic [15:0] SRW_CHARGE_TICKS = 16'h0064;
	localparam logic [15:0] SRW_DISCHARGE_TICKS = 16'h0064;
	localparam logic [15:0] SRW_RELEASE_TICKS = 16'h0100;
	localparam logic [15:0] SRW_REACTION_TICKS = 16'h0004;
	localparam logic [2:0] SRW_TIMEOUT_CYCLES = 3'h4;
	localparam logic [1:0] SRW_LOW_CYCLES = 2'h1;

	// ==========================================================
	// Reset values
	localparam logic SRW_SUPPLY_OK_RST = 1'b0;
	localparam logic SRW_WDOG_OK_RST = 1'b1;

	// ==========================================================
	// Detector states, one-hot
	typedef enum logic [2:0] {
		SRW_DET_LOW = 3'b001,
		SRW_DET_DELAY = 3'b010,
		SRW_DET_OK = 3'b100
	} srw_det_t;

	// ==========================================================
	// Watchdog ramp states, one-hot
	typedef enum logic [2:0] {
		SRW_WD_IDLE = 3'b001,
		SRW_WD_CHARGE = 3'b010,
		SRW_WD_DISCHARGE = 3'b100
	} srw_wd_t;

endpackage

//--- rtl/srw_tick.sv
// One-cycle enable pulse every SRW_TICK_CYC clocks.
// Assumes rst_n is the synchronised reset of the top module.
module srw_tick
	import srw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	output logic tick
);

	typedef struct packed {
		logic [SRW_TB_W-1:0] cnt;
		logic tick;
	} srw_tick_st_t;

	srw_tick_st_t st_q;
	srw_tick_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt == SRW_TB_W'(SRW_TICK_CYC - 1)) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + SRW_TB_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;

endmodule

//--- rtl/srw_ramp_cnt.sv
// Tick counter standing in for the timing capacitor voltage.
// Assumes clr and inc are synchronous controls; inc is a one-cycle tick, clr may be held high for many cycles.
module srw_ramp_cnt
	import srw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic inc,
	output logic [SRW_RAMP_W-1:0] cnt
);

	typedef struct packed {
		logic [SRW_RAMP_W-1:0] cnt;
	} srw_ramp_st_t;

	srw_ramp_st_t st_q;
	srw_ramp_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d.cnt = '0;
		end else if (inc && st_q.cnt != '1) begin
			st_d.cnt = st_q.cnt + SRW_RAMP_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cnt = st_q.cnt;

endmodule

//--- rtl/srw_top.sv
// Supply supervisor and ramp watchdog with reset and status outputs.
// Assumes comparator flags and the trigger are synchronous to the 40 MHz clk.
module srw_top
	import srw_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic below_detect,
	input wire logic above_release,
	input wire logic above_min_level,
	input wire logic watchdog_enable,
	input wire logic load_current_active,
	input wire logic watchdog_trigger_in,
	output logic supply_ok_out,
	output logic watchdog_ok_out,
	output logic combined_status_out
);

	// ==========================================================
	// Reset release
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ==========================================================
	// Timebase and ramps
	logic tick;
	logic [SRW_RAMP_W-1:0] det_cnt;
	logic [SRW_RAMP_W-1:0] wd_cnt;
	logic det_clr;
	logic det_inc;
	logic wd_clr;
	logic wd_inc;

	srw_tick u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	srw_ramp_cnt u_det_ramp (
		.clk(clk),
		.rst_n(rst_n),
		.clr(det_clr),
		.inc(det_inc),
		.cnt(det_cnt)
	);

	srw_ramp_cnt u_wd_ramp (
		.clk(clk),
		.rst_n(rst_n),
		.clr(wd_clr),
		.inc(wd_inc),
		.cnt(wd_cnt)
	);

	// ==========================================================
	// State
	typedef struct packed {
		srw_det_t det;
		logic [SRW_RAMP_W-1:0] dip;
		srw_wd_t wd;
		logic [2:0] cycles;
		logic [1:0] low_cycles;
		logic trig_prev;
		logic supply_ok;
		logic wdog_ok;
		logic combined;
	} srw_st_t;

	srw_st_t st_q;
	srw_st_t st_d;
	logic monitoring;
	logic trig_rise;
	logic trig_take;
	logic cycle_done;

	assign monitoring = watchdog_enable && load_current_active;
	assign trig_rise = watchdog_trigger_in && !st_q.trig_prev;

	always_comb begin
		st_d = st_q;
		det_clr = 1'b0;
		det_inc = 1'b0;
		wd_clr = 1'b0;
		wd_inc = 1'b0;
		cycle_done = 1'b0;
		trig_take = 1'b0;
		st_d.trig_prev = watchdog_trigger_in;

		// Detector: dips are filtered by the reaction counter first.
		if (below_detect) begin
			if (tick && st_q.dip != SRW_REACTION_TICKS) begin
				st_d.dip = st_q.dip + SRW_RAMP_W'(1);
			end
		end else begin
			st_d.dip = '0;
		end
		case (st_q.det)
			SRW_DET_OK: begin
				if (below_detect && st_q.dip == SRW_REACTION_TICKS) begin
					st_d.det = SRW_DET_LOW;
					det_clr = 1'b1;
				end
			end
			SRW_DET_LOW: begin
				det_clr = 1'b1;
				if (above_min_level && above_release && !below_detect) begin
					st_d.det = SRW_DET_DELAY;
				end
			end
			SRW_DET_DELAY: begin
				if (below_detect || !above_release) begin
					st_d.det = SRW_DET_LOW;
					det_clr = 1'b1;
				end else if (det_cnt >= SRW_RELEASE_TICKS) begin
					st_d.det = SRW_DET_OK;
				end else begin
					det_inc = tick;
				end
			end
			default: st_d.det = SRW_DET_LOW;
		endcase
		st_d.supply_ok = (st_d.det == SRW_DET_OK);

		// Watchdog ramp.
		case (st_q.wd)
			SRW_WD_IDLE: begin
				wd_clr = 1'b1;
				st_d.cycles = '0;
				if (monitoring) begin
					st_d.wd = SRW_WD_CHARGE;
				end
			end
			SRW_WD_CHARGE: begin
				wd_inc = tick;
				if (wd_cnt >= SRW_CHARGE_TICKS) begin
					st_d.wd = SRW_WD_DISCHARGE;
					wd_clr = 1'b1;
				end
			end
			SRW_WD_DISCHARGE: begin
				wd_inc = tick;
				if (wd_cnt >= SRW_DISCHARGE_TICKS) begin
					cycle_done = 1'b1;
					st_d.wd = SRW_WD_CHARGE;
					wd_clr = 1'b1;
				end
			end
			default: st_d.wd = SRW_WD_IDLE;
		endcase

		if (st_q.wd != SRW_WD_IDLE && monitoring && st_q.wdog_ok && trig_rise) begin
			trig_take = 1'b1;
			st_d.wd = SRW_WD_CHARGE;
			wd_clr = 1'b1;
			st_d.cycles = '0;
		end else if (cycle_done) begin
			if (!st_q.wdog_ok) begin
				st_d.low_cycles = st_q.low_cycles + 2'h1;
				if (st_q.low_cycles + 2'h1 == SRW_LOW_CYCLES) begin
					st_d.wdog_ok = 1'b1;
					st_d.cycles = '0;
				end
			end else if (st_q.cycles + 3'h1 == SRW_TIMEOUT_CYCLES) begin
				st_d.wdog_ok = 1'b0;
				st_d.low_cycles = '0;
				st_d.cycles = '0;
			end else begin
				st_d.cycles = st_q.cycles + 3'h1;
			end
		end

		// Deactivation: high output stops now, low output waits for cycle end.
		if (!monitoring && st_q.wd != SRW_WD_IDLE && !trig_take) begin
			if (st_q.wdog_ok) begin
				st_d.wd = SRW_WD_IDLE;
				st_d.cycles = '0;
			end else if (cycle_done) begin
				st_d.wd = SRW_WD_IDLE;
				st_d.wdog_ok = 1'b1;
			end
		end

		st_d.combined = st_d.supply_ok && st_d.wdog_ok;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.det <= SRW_DET_LOW;
			st_q.dip <= '0;
			st_q.wd <= SRW_WD_IDLE;
			st_q.cycles <= '0;
			st_q.low_cycles <= '0;
			st_q.trig_prev <= 1'b0;
			st_q.supply_ok <= SRW_SUPPLY_OK_RST;
			st_q.wdog_ok <= SRW_WDOG_OK_RST;
			st_q.combined <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign supply_ok_out = st_q.supply_ok;
	assign watchdog_ok_out = st_q.wdog_ok;
	assign combined_status_out = st_q.combined;

	// ==========================================================
	// Checks
	AST_COMBINED: assert property (@(posedge clk) disable iff (!rst_n)
		combined_status_out == (supply_ok_out && watchdog_ok_out))
		else $error("Combined status differs from AND of outputs.");

	AST_DETECT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q.det == SRW_DET_OK && below_detect && st_q.dip == SRW_REACTION_TICKS)
		|=> !supply_ok_out)
		else $error("Supply-ok did not fall on detect.");

	AST_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		(!supply_ok_out && !above_release) |=> !supply_ok_out)
		else $error("Supply-ok rose below release threshold.");

	AST_RELEASE_RISE: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q.det == SRW_DET_DELAY && det_cnt >= SRW_RELEASE_TICKS && !below_detect
		&& above_release) |=> supply_ok_out)
		else $error("Supply-ok not released at end of delay.");

	AST_RELEASE_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(supply_ok_out) |-> $past(det_cnt) >= SRW_RELEASE_TICKS)
		else $error("Supply-ok released before delay.");

	AST_DIP_FILTER: assert property (@(posedge clk) disable iff (!rst_n)
		(supply_ok_out && st_q.dip != SRW_REACTION_TICKS) |=> supply_ok_out)
		else $error("Short dip dropped supply-ok.");

	AST_RAMP_TURN: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q.wd == SRW_WD_CHARGE && wd_cnt >= SRW_CHARGE_TICKS && monitoring && !trig_take)
		|=> st_q.wd == SRW_WD_DISCHARGE)
		else $error("Ramp did not turn to discharge at the upper threshold.");

	AST_TRIG_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		trig_take |=> (st_q.wd == SRW_WD_CHARGE && st_q.cycles == 3'h0 && watchdog_ok_out))
		else $error("Trigger did not restart the cycle.");

	AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
		(cycle_done && watchdog_ok_out && !trig_take && monitoring && st_q.cycles == 3'h3)
		|=> !watchdog_ok_out)
		else $error("No timeout after four cycles.");

	AST_DEACT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(!monitoring && watchdog_ok_out && st_q.wd != SRW_WD_IDLE)
		|=> (st_q.cycles == 3'h0 && st_q.wd == SRW_WD_IDLE))
		else $error("Cycle count not cleared on deactivation.");

	AST_LOW_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(!watchdog_ok_out && !cycle_done) |=> !watchdog_ok_out)
		else $error("Watchdog-ok rose before cycle end.");

	AST_LOW_END: assert property (@(posedge clk) disable iff (!rst_n)
		(!watchdog_ok_out && cycle_done) |=> watchdog_ok_out)
		else $error("Watchdog-ok stayed low after one cycle.");

	AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(watchdog_ok_out) |-> (st_q.cycles == 3'h0 && st_q.wd != SRW_WD_DISCHARGE))
		else $error("Monitoring did not resume cleanly after the low period.");

	AST_NO_TRIG_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		(!watchdog_ok_out || !monitoring) |-> !trig_take)
		else $error("Trigger taken while not allowed.");

	AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
		(!watchdog_enable && watchdog_ok_out) |=> st_q.wd == SRW_WD_IDLE)
		else $error("Watchdog kept running while disabled.");

	COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n) $rose(supply_ok_out));
	COV_TIMEOUT: cover property (@(posedge clk) disable iff (!rst_n) $fell(watchdog_ok_out));
	COV_RECOVER: cover property (@(posedge clk) disable iff (!rst_n) $rose(watchdog_ok_out));
	COV_TRIGGER: cover property (@(posedge clk) disable iff (!rst_n) trig_take);

endmodule

//--- dv/srw_mcu_model.sv
// Model of the monitored controller that sends rising-edge watchdog triggers.
// Assumes kick is a one-cycle request from the bench, driven at the clk rising edge.
module srw_mcu_model
(
	input wire logic clk,
	input wire logic kick,
	output logic trigger
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Trigger pulse
	localparam int HIGH_CYC = 8;
	int hold_cnt;

	initial trigger = 1'b0;
	initial hold_cnt = 0;

	// The line idles low, as its pull-down would leave it, so each pulse
	// is preceded by low samples and reads as a fresh rising edge.
	always @(posedge clk) begin
		if (kick && hold_cnt == 0) begin
			trigger <= 1'b1;
			hold_cnt <= HIGH_CYC;
		end else if (hold_cnt > 1) begin
			hold_cnt <= hold_cnt - 1;
		end else begin
			trigger <= 1'b0;
			hold_cnt <= 0;
		end
	end
endmodule

//--- dv/srw_top_test.sv
// Self-checking bench for the supply supervisor and ramp watchdog.
// Assumes the package timing constants as delivered: 40 clk per tick.
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("[FAIL] %s expected %b seen %b", nm, e, g); \
	end \
end

module srw_top_test
	import srw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Timing derived from the package
	localparam int TICK = int'(SRW_TICK_CYC);
	localparam int CYC_T = int'(SRW_CHARGE_TICKS) + int'(SRW_DISCHARGE_TICKS);
	localparam int REL_T = int'(SRW_RELEASE_TICKS);
	localparam int TO_T = CYC_T * int'(SRW_TIMEOUT_CYCLES);
	localparam int LIMIT = (2 * TO_T + 2 * CYC_T) * TICK + 1000;

	logic clk;
	logic arst_n;
	logic below_detect;
	logic above_release;
	logic above_min_level;
	logic watchdog_enable;
	logic load_current_active;
	logic watchdog_trigger_in;
	logic kick;
	logic supply_ok_out;
	logic watchdog_ok_out;
	logic combined_status_out;
	int n_fail;
	int comparisons;

	srw_top uut (
		.clk(clk),
		.arst_n(arst_n),
		.below_detect(below_detect),
		.above_release(above_release),
		.above_min_level(above_min_level),
		.watchdog_enable(watchdog_enable),
		.load_current_active(load_current_active),
		.watchdog_trigger_in(watchdog_trigger_in),
		.supply_ok_out(supply_ok_out),
		.watchdog_ok_out(watchdog_ok_out),
		.combined_status_out(combined_status_out)
	);

	srw_mcu_model u_mcu (
		.clk(clk),
		.kick(kick),
		.trigger(watchdog_trigger_in)
	);

	always #12.5 clk = ~clk;

	// ==========================================================
	// Helpers
	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge clk);
	endtask

	task automatic test_done();
		$display("Counts: %0d comparisons, %0d failures", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Detector: release delay, short and long dips, hysteresis band
	task automatic supply_seq();
		ticks(REL_T - 6);
		#1;
		`CHK("supply_ok inside delay", 1'b0, supply_ok_out)
		ticks(12);
		#1;
		`CHK("supply_ok released", 1'b1, supply_ok_out)
		`CHK("combined both ok", 1'b1, combined_status_out)
		ticks(1);
		below_detect <= 1'b1;
		above_release <= 1'b0;
		ticks(2);
		below_detect <= 1'b0;
		above_release <= 1'b1;
		ticks(6);
		#1;
		`CHK("supply_ok short dip", 1'b1, supply_ok_out)
		ticks(1);
		below_detect <= 1'b1;
		above_release <= 1'b0;
		ticks(6);
		#1;
		`CHK("supply_ok long dip", 1'b0, supply_ok_out)
		`CHK("combined supply low", 1'b0, combined_status_out)
		ticks(4);
		below_detect <= 1'b0;
		ticks(20);
		#1;
		`CHK("supply_ok between thresholds", 1'b0, supply_ok_out)
		ticks(1);
		above_min_level <= 1'b0;
		above_release <= 1'b1;
		ticks(10);
		#1;
		`CHK("supply_ok below min level", 1'b0, supply_ok_out)
		ticks(1);
		above_min_level <= 1'b1;
		ticks(REL_T - 6);
		#1;
		`CHK("supply_ok second delay", 1'b0, supply_ok_out)
		ticks(12);
		#1;
		`CHK("supply_ok second release", 1'b1, supply_ok_out)
	endtask

	// ==========================================================
	// Watchdog: restart by trigger, clear on disable, timeout, low period
	task automatic watchdog_seq();
		ticks(CYC_T + 50);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		ticks(650);
		#1;
		`CHK("wd_ok after trigger restart", 1'b1, watchdog_ok_out)
		ticks(1);
		watchdog_enable <= 1'b0;
		ticks(10);
		watchdog_enable <= 1'b1;
		ticks(CYC_T);
		#1;
		`CHK("wd_ok after restart from idle", 1'b1, watchdog_ok_out)
		ticks(TO_T - CYC_T - 5);
		#1;
		`CHK("wd_ok count cleared", 1'b1, watchdog_ok_out)
		ticks(10);
		#1;
		`CHK("wd_ok timeout", 1'b0, watchdog_ok_out)
		`CHK("combined wd low", 1'b0, combined_status_out)
		ticks(20);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		ticks(25);
		load_current_active <= 1'b0;
		ticks(CYC_T - 70);
		#1;
		`CHK("wd_ok held low after stop", 1'b0, watchdog_ok_out)
		ticks(30);
		#1;
		`CHK("wd_ok after low cycle", 1'b1, watchdog_ok_out)
		`CHK("combined recovered", 1'b1, combined_status_out)
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		below_detect = 1'b0;
		above_release = 1'b1;
		above_min_level = 1'b1;
		watchdog_enable = 1'b1;
		load_current_active = 1'b1;
		kick = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		#1;
		`CHK("supply_ok in reset", 1'b0, supply_ok_out)
		`CHK("wd_ok in reset", 1'b1, watchdog_ok_out)
		`CHK("combined in reset", 1'b0, combined_status_out)
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		fork
			supply_seq();
			watchdog_seq();
		join
		test_done();
	end

	// Cuts a hang short after the longest expected run.
	initial begin
		repeat (LIMIT) @(posedge clk);
		n_fail++;
		$display("[FAIL] run length expected end seen hang");
		test_done();
	end
endmodule
